// file: charge_port_pkg.sv
// Purpose: shared constants and types for the charge port wake control block
// Assumes: 100 MHz system clock, slow timebase derived by a prescaler
// Notes:   mode codes are msb-first three-pin codes plus the limit select bit
package charge_port_pkg;

    // ****************************************
    // clock and timebase
    // ****************************************
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned TICK_HZ       = 1000;
    localparam int unsigned TICK_DIV      = CLK_HZ / TICK_HZ;
    localparam int unsigned TICK_MS       = 1000 / TICK_HZ;
    localparam int unsigned TIMER_W       = 17;

    // ****************************************
    // intervals, in milliseconds as printed
    // ****************************************
    localparam int unsigned PRESTEP_MS    = 100;
    localparam int unsigned LOW_CUR_MS    = 15_000;
    localparam int unsigned DISCHARGE_MS  = 2_000;
    localparam int unsigned FS_HOLD_MS    = 60_000;
    localparam int unsigned PRESTEP_TICKS = PRESTEP_MS / TICK_MS;
    localparam int unsigned LOW_CUR_TICKS = LOW_CUR_MS / TICK_MS + 1;
    localparam int unsigned DISCH_TICKS   = DISCHARGE_MS / TICK_MS + 1;
    localparam int unsigned FS_HOLD_TICKS = FS_HOLD_MS / TICK_MS;

    // ****************************************
    // mode pin codes (mode_pin_msb, mode_pin_mid, mode_pin_lsb)
    // ****************************************
    localparam logic [2:0] MODE_CHG_STD   = 3'h7;
    localparam logic [2:0] MODE_AUTO_DCP  = 3'h3;
    localparam logic [2:0] MODE_PRIM_STD  = 3'h2;
    localparam logic [2:0] MODE_ALT_STD   = 3'h6;
    localparam logic [3:0] MODE_DEEP_CHG  = 4'h3;

    // ****************************************
    // interrupt status and mask bit positions
    // ****************************************
    localparam int unsigned EV_LS_ATTACH  = 0;
    localparam int unsigned EV_FS_WAKE    = 1;
    localparam int unsigned EV_HS_SEEN    = 2;
    localparam int unsigned EV_STATUS_LO  = 3;
    localparam int unsigned EV_STATUS_HI  = 4;
    localparam int unsigned EV_W          = 5;

    // ****************************************
    // register indexes
    // ****************************************
    localparam logic [1:0] REG_IRQ_STAT   = 2'h0;
    localparam logic [1:0] REG_IRQ_MASK   = 2'h1;
    localparam logic [1:0] REG_STATE      = 2'h2;
    localparam logic [EV_W-1:0] MASK_RST  = 5'h00;

    typedef enum logic [2:0] {
        PW_OFF,
        PW_CHARGE,
        PW_LOWPOWER,
        PW_DISCHARGE
    } pw_state_e;

    typedef enum logic [1:0] {
        DCP_IDLE,
        DCP_PRESTEP,
        DCP_SHORTED
    } dcp_state_e;

endpackage

// file: tick_if.sv
// Purpose: carries the slow timebase tick between the block's modules
// Assumes: one system clock domain
// Notes:   tick is a one-cycle pulse
`timescale 1ns/100ps
interface tick_if;
    logic tick;
    modport source (output tick);
    modport sink   (input  tick);
endinterface

// file: tick_gen.sv
// Purpose: divides the system clock into a slow timebase tick
// Assumes: clock enable freezes the divider
// Notes:   the tick is one system cycle long
`timescale 1ns/100ps
module tick_gen
    import charge_port_pkg::*;
#(
    parameter int unsigned DIV = TICK_DIV
) (
    input  wire logic  clk_sys,
    input  wire logic  rstn,
    input  wire logic  clk_en,
    tick_if.source     tk
);
    logic [31:0] count;
    wire         wrap = (count == DIV - 1);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            count <= 32'h0;
        end else if (clk_en) begin
            count <= wrap ? 32'h0 : count + 32'h1;
        end
    end

    assign tk.tick = clk_en & wrap;
endmodule

// file: sync2.sv
// Purpose: two-flop synchroniser for a bundle of pin levels
// Assumes: inputs are asynchronous levels
// Notes:   first stage is read only by the second
`timescale 1ns/100ps
module sync2 #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         rstn,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            meta <= '0;
            q    <= '0;
        end else if (clk_en) begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// file: charge_port_wake_control.sv
// Purpose: mode decode, auto charging pre-step, usb wake tracking, power wake
// Assumes: analog comparators arrive as asynchronous digital levels
// Notes:   register port has read data one cycle after the read strobe
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/100ps

// What this block does
// R1: auto dedicated charge first shorts lines at 1.2 V, then shorted mode
// R2: mode 111 to 011 keeps wake override instead of normal mode change
// R3: mode 010 to 011 also keeps the wake override
// R4: mode code is msb first; limit select ignored for override decision
// R5: 110 to 011 is no override; passing 111 discharges the port
// R6: watch data lines for attach only in standard or charging modes
// R7: d minus high is low speed, d plus high alone is full speed
// R8: d plus low after full speed connect marks high speed, no wake
// R9: full speed becomes wake source only after 60 s connected
// R10: no deadline on mode pins returning after a wake
// R11: data lines stay connected to host throughout the override
// R12: load wake function active only with mode setting 0011
// R13: status output low while load charges in load wake function
// R14: under 45 mA for over 15 s: 55 mA limit and status released
// R15: in low power state, hitting 55 mA limit drives status low again
// R16: after reasserting status, discharge output for over 2 s
// R17: after discharge, re-enable switch with high limit, back to charging
// R18: inputs synchronised; long intervals counted from divided timebase
// R19: low current timer restarts when current returns above threshold
module charge_port_wake_control
    import charge_port_pkg::*;
#(
    parameter int unsigned PRESTEP_T = PRESTEP_TICKS,
    parameter int unsigned LOW_CUR_T = LOW_CUR_TICKS,
    parameter int unsigned DISCH_T   = DISCH_TICKS,
    parameter int unsigned FS_HOLD_T = FS_HOLD_TICKS,
    parameter int unsigned DIV       = TICK_DIV
) (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        clk_en,
    input  wire logic        mode_pin_msb,
    input  wire logic        mode_pin_mid,
    input  wire logic        mode_pin_lsb,
    input  wire logic        limit_select,
    input  wire logic        dp_high,
    input  wire logic        dm_high,
    input  wire logic        iout_below_low,
    input  wire logic        iout_at_limit,
    input  wire logic [1:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             status_n,
    output logic             high_limit_setting,
    output logic             low_power_limit,
    output logic             out_discharge,
    output logic             switch_on,
    output logic             lines_to_host,
    output logic             lines_shorted,
    output logic             lines_at_1v2,
    output logic             wake_override,
    output logic             irq
);

    // ****************************************
    // input synchronisation
    // ****************************************
    logic [7:0] pins_s;
    tick_if     tk ();

    sync2 #(.W(8)) u_sync ( // [R18]
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .clk_en  (clk_en),
        .d       ({mode_pin_msb, mode_pin_mid, mode_pin_lsb, limit_select,
                   dp_high, dm_high, iout_below_low, iout_at_limit}),
        .q       (pins_s)
    );

    tick_gen #(.DIV(DIV)) u_tick ( // [R18]
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .clk_en  (clk_en),
        .tk      (tk)
    );

    wire [2:0] mode_now  = pins_s[7:5]; // [R4]
    wire       lim_s     = pins_s[4];
    wire       dp_s      = pins_s[3];
    wire       dm_s      = pins_s[2];
    wire       low_cur_s = pins_s[1];
    wire       at_lim_s  = pins_s[0];
    wire       tick      = tk.tick;

    // ****************************************
    // mode decode and wake override
    // ****************************************
    logic [2:0] mode_prev;
    logic       ovr;
    logic       disch_111;
    wire        mode_chg   = (mode_now != mode_prev);
    wire        to_auto    = mode_chg && (mode_now == MODE_AUTO_DCP);
    // limit_select deliberately plays no part here
    wire        ovr_start  = to_auto && ((mode_prev == MODE_CHG_STD) ||
                             (mode_prev == MODE_PRIM_STD)); // [R2] [R3] [R4]
    wire        std_mode   = (mode_now == MODE_CHG_STD) ||
                             (mode_now == MODE_PRIM_STD) ||
                             (mode_now == MODE_ALT_STD);
    wire        deep_mode  = ({mode_now, lim_s} == MODE_DEEP_CHG); // [R12]
    wire        enter_111  = mode_chg && (mode_now == MODE_CHG_STD) &&
                             (mode_prev != MODE_CHG_STD);

    // override holds as long as auto mode holds; no return deadline
    wire next_ovr = ovr_start ? 1'b1 :
                    (mode_now != MODE_AUTO_DCP) ? 1'b0 : ovr; // [R10]

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mode_prev <= 3'h0;
            ovr       <= 1'b0;
            disch_111 <= 1'b0;
        end else if (clk_en) begin
            mode_prev <= mode_now;
            ovr       <= next_ovr;
            // a transient 111 from a 110 to 011 step still discharges
            disch_111 <= enter_111 && (mode_prev != MODE_AUTO_DCP); // [R5]
        end
    end

    // ****************************************
    // auto dedicated charge pre-step
    // ****************************************
    dcp_state_e         dcp;
    logic [TIMER_W-1:0] dcp_t;
    wire auto_dcp_mode = (mode_now == MODE_AUTO_DCP) && !ovr && !ovr_start;
    wire pre_done      = (dcp_t >= TIMER_W'(PRESTEP_T));

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            dcp   <= DCP_IDLE;
            dcp_t <= '0;
        end else if (clk_en) begin
            if (!auto_dcp_mode) begin
                dcp   <= DCP_IDLE;
                dcp_t <= '0;
            end else begin
                unique case (dcp)
                    DCP_IDLE: begin
                        dcp   <= DCP_PRESTEP; // [R1]
                        dcp_t <= '0;
                    end
                    DCP_PRESTEP: begin
                        if (pre_done) begin
                            dcp <= DCP_SHORTED; // [R1]
                        end else if (tick) begin
                            dcp_t <= dcp_t + 1'b1;
                        end
                    end
                    DCP_SHORTED: dcp <= DCP_SHORTED;
                    default: dcp <= DCP_IDLE;
                endcase
            end
        end
    end

    // ****************************************
    // usb attachment tracking
    // ****************************************
    logic               ls_att;
    logic               fs_seen;
    logic               hs_seen;
    logic               fs_wake;
    logic [TIMER_W-1:0] fs_t;
    wire watch   = std_mode; // [R6]
    wire ls_now  = watch && dm_s && !dp_s; // [R7]
    wire fs_now  = watch && dp_s && !dm_s; // [R7]
    wire detach  = watch && !dp_s && !dm_s;
    wire hs_mark = fs_seen && !dp_s && !hs_seen; // [R8]
    wire fs_ripe = fs_seen && !hs_seen && !fs_wake &&
                   (fs_t >= TIMER_W'(FS_HOLD_T)); // [R9]

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ls_att  <= 1'b0;
            fs_seen <= 1'b0;
            hs_seen <= 1'b0;
            fs_wake <= 1'b0;
            fs_t    <= '0;
        end else if (clk_en && watch) begin
            ls_att <= ls_now;
            if (fs_now && !fs_seen) begin
                fs_seen <= 1'b1;
                fs_t    <= '0;
            end else if (hs_mark) begin
                hs_seen <= 1'b1; // [R8]
            end else if (detach && !fs_seen) begin
                hs_seen <= 1'b0;
            end
            if (fs_ripe) begin
                fs_wake <= 1'b1; // [R9]
            end else if (fs_seen && !hs_seen && tick && !fs_wake) begin
                fs_t <= fs_t + 1'b1;
            end
            // hs idles with both lines low; only a new d plus connect restarts
            if (fs_now && hs_seen) begin
                hs_seen <= 1'b0; // [R8]
                fs_wake <= 1'b0;
                fs_t    <= '0;
            end
        end
    end

    // ****************************************
    // load wake function
    // ****************************************
    pw_state_e          pw;
    logic [TIMER_W-1:0] pw_t;
    wire low_done  = (pw_t >= TIMER_W'(LOW_CUR_T));
    wire disch_end = (pw_t >= TIMER_W'(DISCH_T));

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pw   <= PW_OFF;
            pw_t <= '0;
        end else if (clk_en) begin
            if (!deep_mode) begin
                pw   <= PW_OFF; // [R12]
                pw_t <= '0;
            end else begin
                unique case (pw)
                    PW_OFF: begin
                        pw   <= PW_CHARGE;
                        pw_t <= '0;
                    end
                    PW_CHARGE: begin
                        if (!low_cur_s) begin
                            pw_t <= '0; // [R19]
                        end else if (low_done) begin
                            pw   <= PW_LOWPOWER; // [R14]
                            pw_t <= '0;
                        end else if (tick) begin
                            pw_t <= pw_t + 1'b1;
                        end
                    end
                    PW_LOWPOWER: begin
                        if (at_lim_s) begin
                            pw   <= PW_DISCHARGE; // [R15]
                            pw_t <= '0;
                        end
                    end
                    PW_DISCHARGE: begin
                        if (disch_end) begin
                            pw   <= PW_CHARGE; // [R17]
                            pw_t <= '0;
                        end else if (tick) begin
                            pw_t <= pw_t + 1'b1; // [R16]
                        end
                    end
                    default: pw <= PW_OFF;
                endcase
            end
        end
    end

    // ****************************************
    // port outputs
    // ****************************************
    wire pw_dis = (pw == PW_DISCHARGE);
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            status_n           <= 1'b1;
            high_limit_setting <= 1'b1;
            low_power_limit    <= 1'b0;
            out_discharge      <= 1'b0;
            switch_on          <= 1'b0;
            lines_to_host      <= 1'b0;
            lines_shorted      <= 1'b0;
            lines_at_1v2       <= 1'b0;
            wake_override      <= 1'b0;
        end else if (clk_en) begin
            status_n           <= !(pw == PW_CHARGE || pw_dis); // [R13] [R15]
            low_power_limit    <= (pw == PW_LOWPOWER); // [R14]
            high_limit_setting <= (pw != PW_LOWPOWER); // [R17]
            out_discharge      <= pw_dis || disch_111; // [R5] [R16]
            switch_on          <= !pw_dis && !disch_111;
            lines_to_host      <= std_mode || ovr; // [R11]
            lines_shorted      <= (dcp != DCP_IDLE) && !ovr;
            lines_at_1v2       <= (dcp == DCP_PRESTEP); // [R1]
            wake_override      <= ovr;
        end
    end

    // ****************************************
    // interrupts and register port
    // ****************************************
    logic [EV_W-1:0] irq_stat;
    logic [EV_W-1:0] irq_mask;
    logic            pw_prev_lo;
    wire [EV_W-1:0]  ev;
    wire             wr_stat = reg_wr && (reg_addr == REG_IRQ_STAT);
    wire             wr_mask = reg_wr && (reg_addr == REG_IRQ_MASK);
    wire [EV_W-1:0]  w1c = wr_stat ? reg_wdata[EV_W-1:0] : '0;

    assign ev[EV_LS_ATTACH] = ls_now && !ls_att;
    assign ev[EV_FS_WAKE]   = fs_ripe && watch;
    assign ev[EV_HS_SEEN]   = hs_mark && watch;
    assign ev[EV_STATUS_LO] = !status_n && !pw_prev_lo;
    assign ev[EV_STATUS_HI] = status_n && pw_prev_lo;

    wire [31:0] rd_mux =
        (reg_addr == REG_IRQ_STAT) ? {27'h0, irq_stat} :
        (reg_addr == REG_IRQ_MASK) ? {27'h0, irq_mask} :
        (reg_addr == REG_STATE)    ? {20'h0, ovr, fs_wake, hs_seen, ls_att,
                                      1'b0, pw, 2'h0, dcp} : 32'h0;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irq_stat   <= '0;
            irq_mask   <= MASK_RST;
            pw_prev_lo <= 1'b0;
            reg_rdata  <= 32'h0;
            irq        <= 1'b0;
        end else if (clk_en) begin
            // set wins over a simultaneous write-one clear
            irq_stat   <= (irq_stat & ~w1c) | ev;
            irq_mask   <= wr_mask ? reg_wdata[EV_W-1:0] : irq_mask;
            pw_prev_lo <= !status_n;
            reg_rdata  <= reg_rd ? rd_mux : 32'h0;
            irq        <= |(irq_stat & irq_mask);
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_prestep_first;
        @(posedge clk_sys) disable iff (!rstn)
        (clk_en && dcp == DCP_IDLE && auto_dcp_mode) |=>
            (dcp == DCP_PRESTEP);
    endproperty
    a_prestep_first: assert property (p_prestep_first) // [R1]
        else $error("pre-step skipped");

    property p_override;
        @(posedge clk_sys) disable iff (!rstn)
        (clk_en && ovr_start) |=> ovr;
    endproperty
    a_override: assert property (p_override) // [R2]
        else $error("override not taken");

    property p_no_ovr_110;
        @(posedge clk_sys) disable iff (!rstn)
        (clk_en && to_auto && mode_prev == MODE_ALT_STD) |=> !ovr;
    endproperty
    a_no_ovr_110: assert property (p_no_ovr_110) // [R5]
        else $error("110 to 011 overrode");

    property p_hs_mark;
        @(posedge clk_sys) disable iff (!rstn)
        (clk_en && watch && hs_mark && !(detach && hs_seen)) |=> hs_seen;
    endproperty
    a_hs_mark: assert property (p_hs_mark) // [R8]
        else $error("high speed not marked");

    property p_pw_off;
        @(posedge clk_sys) disable iff (!rstn)
        (clk_en && !deep_mode) |=> (pw == PW_OFF);
    endproperty
    a_pw_off: assert property (p_pw_off) // [R12]
        else $error("load wake active outside deep mode");

    property p_status_charge;
        @(posedge clk_sys) disable iff (!rstn)
        (clk_en && pw == PW_CHARGE) |=> !status_n;
    endproperty
    a_status_charge: assert property (p_status_charge) // [R13]
        else $error("status not low while charging");

    property p_low_limit;
        @(posedge clk_sys) disable iff (!rstn)
        (clk_en && pw == PW_LOWPOWER) |=> (low_power_limit && status_n);
    endproperty
    a_low_limit: assert property (p_low_limit) // [R14]
        else $error("low power outputs wrong");

    property p_restart;
        @(posedge clk_sys) disable iff (!rstn)
        (clk_en && deep_mode && pw == PW_CHARGE && !low_cur_s) |=>
            (pw_t == '0);
    endproperty
    a_restart: assert property (p_restart) // [R19]
        else $error("low current timer not restarted");

    property p_discharge;
        @(posedge clk_sys) disable iff (!rstn)
        (clk_en && pw == PW_LOWPOWER && at_lim_s && deep_mode) |=>
            ##1 (out_discharge && !status_n);
    endproperty
    a_discharge: assert property (p_discharge) // [R15]
        else $error("no discharge on limit hit");
endmodule

// file: usb_load_model.sv
// Purpose: far side model: attached usb device and port load current
// Assumes: comparator levels follow the modelled lines and load
// Notes:   kind 0 none, 1 low speed, 2 full speed, 3 high speed
`timescale 1ns/100ps
module usb_load_model (
    input  wire logic       clk_sys,
    input  wire logic [1:0] kind,
    input  wire logic [7:0] load_ma,
    input  wire logic       low_power_limit,
    output logic            dp_high,
    output logic            dm_high,
    output logic            iout_below_low,
    output logic            iout_at_limit
);
    logic [5:0] age = 6'h00;

    always @(posedge clk_sys) begin
        if (kind == 2'h0) begin
            age <= 6'h00;
        end else if (age != 6'h3f) begin
            age <= age + 6'h01;
        end
    end
    // detached lines sit at ground through the host pull-downs
    assign dm_high = (kind == 2'h1);
    // high speed drops its d plus pull-up after negotiation
    assign dp_high = (kind == 2'h2) || (kind == 2'h3 && age < 6'h0c);
    assign iout_below_low = (load_ma < 8'h2d);
    assign iout_at_limit = low_power_limit && (load_ma >= 8'h37);
endmodule

// file: tb_charge_port_wake_control.sv
// Purpose: self-checking bench for the charge port wake control block
// Assumes: shortened tick divider and interval parameters
// Notes:   register reads are checked from a queue of expected words
`timescale 1ns/100ps
module tb_charge_port_wake_control;
    import charge_port_pkg::*;
    localparam int TK = 4;
    localparam int PT = 5;
    localparam int LT = 6;
    localparam int DT = 5;
    localparam int FT = 8;
    logic        clk_sys = 1'b0;
    logic        rstn = 1'b0;
    logic        lim = 1'b0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        rd_d = 1'b0;
    logic        seen;
    logic [2:0]  mode = 3'h0;
    logic [1:0]  reg_addr = 2'h0;
    logic [1:0]  kind = 2'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic [31:0] r;
    logic [7:0]  load_ma = 8'h00;
    logic        dp_high, dm_high, below, at_lim, status_n, hi_lim, lp_lim;
    logic        disch, sw_on, to_host, shorted, at_1v2, ovr, irq;
    logic [63:0] exp_q[$];
    logic [63:0] e;
    logic [2:0]  frm [4] = '{3'h7, 3'h2, 3'h6, 3'h0};
    int          error_cnt = 0;
    int          samples_checked = 0;

    charge_port_wake_control #(.PRESTEP_T(PT), .LOW_CUR_T(LT), .DISCH_T(DT),
        .FS_HOLD_T(FT), .DIV(TK)) charge_port_wake_control_inst (
        .clk_sys(clk_sys), .rstn(rstn), .clk_en(1'b1),
        .mode_pin_msb(mode[2]), .mode_pin_mid(mode[1]), .mode_pin_lsb(mode[0]),
        .limit_select(lim), .dp_high(dp_high), .dm_high(dm_high),
        .iout_below_low(below), .iout_at_limit(at_lim), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .status_n(status_n), .high_limit_setting(hi_lim),
        .low_power_limit(lp_lim), .out_discharge(disch), .switch_on(sw_on),
        .lines_to_host(to_host), .lines_shorted(shorted),
        .lines_at_1v2(at_1v2), .wake_override(ovr), .irq(irq));
    usb_load_model usb_load_model_inst (.clk_sys(clk_sys), .kind(kind),
        .load_ma(load_ma), .low_power_limit(lp_lim), .dp_high(dp_high),
        .dm_high(dm_high), .iout_below_low(below), .iout_at_limit(at_lim));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] act, input logic [31:0] ex,
                       input string msg);
        samples_checked++;
        if (act !== ex) begin
            error_cnt++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // reads carry the expected word in d and the bits that matter in m
    task automatic bus(input logic w, input logic [1:0] a,
                       input logic [31:0] d, input logic [31:0] m);
        @(posedge clk_sys);
        reg_wr    <= w;
        reg_rd    <= ~w;
        reg_addr  <= a;
        reg_wdata <= d;
        if (!w) exp_q.push_back({m, d & m});
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask
    task automatic setm(input logic [2:0] m, input logic l);
        @(posedge clk_sys);
        mode <= m;
        lim  <= l;
        cyc(6);
    endtask
    task automatic rst;
        @(posedge clk_sys);
        rstn <= 1'b0;
        kind <= 2'h0;
        cyc(3);
        rstn <= 1'b1;
        cyc(2);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        rd_d <= reg_rd;
        if (rd_d === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            chk(reg_rdata & e[63:32], e[31:0], "register read");
        end
    end
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        cyc(3000);
        error_cnt++;
        $display("MISMATCH %0t watchdog expired", $time);
        finish_test();
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        void'($urandom(32'h9425));
        cyc(2);
        chk({25'h0, status_n, hi_lim, sw_on, lp_lim, disch, ovr, irq},
            32'h60, "reset values");
        cyc(1);
        rstn <= 1'b1;
        r = $urandom & 32'h1f;
        bus(1'b1, 2'h1, r, 32'h0);
        bus(1'b0, 2'h1, r, 32'h1f);
        bus(1'b1, 2'h3, 32'hffffffff, 32'h0);
        bus(1'b0, 2'h3, 32'h0, 32'hffffffff);
        bus(1'b0, 2'h2, 32'h0, 32'h777);
        $display("test registers done");
        foreach (frm[i]) begin
            setm(frm[i], 1'($urandom));
            setm(3'h3, 1'($urandom));
            cyc(30);
            chk(32'(ovr), 32'(i < 2), "override");
            chk(32'(to_host), 32'(i < 2), "host lines");
            setm(3'h0, 1'b0);
        end
        setm(3'h6, 1'b0);
        @(posedge clk_sys) mode <= 3'h7;
        @(posedge clk_sys) mode <= 3'h3;
        seen = 1'b0;
        repeat (8) @(posedge clk_sys) seen |= disch;
        chk(32'(seen), 32'h1, "discharge via 111");
        setm(3'h0, 1'b0);
        setm(3'h3, 1'b0);
        cyc((PT - 2) * TK);
        chk({at_1v2, shorted}, 32'h3, "pre-step");
        cyc(3 * TK);
        chk({at_1v2, shorted}, 32'h1, "shorted");
        $display("test mode changes done");
        rst();
        bus(1'b1, 2'h1, 32'h1, 32'h0);
        kind <= 2'h1;
        cyc(20);
        bus(1'b0, 2'h0, 32'h0, 32'h1);
        setm(3'h7, 1'b0);
        bus(1'b0, 2'h0, 32'h1, 32'h1);
        chk(32'(irq), 32'h1, "irq raised");
        bus(1'b1, 2'h1, 32'h0, 32'h0);
        cyc(3);
        chk(32'(irq), 32'h0, "irq masked");
        kind <= 2'h0;
        bus(1'b1, 2'h0, 32'h1, 32'h0);
        bus(1'b0, 2'h0, 32'h0, 32'h1);
        kind <= 2'h3;
        cyc(40);
        bus(1'b0, 2'h2, 32'h200, 32'h600);
        kind <= 2'h0;
        cyc(10);
        kind <= 2'h2;
        cyc((FT - 2) * TK);
        bus(1'b0, 2'h2, 32'h0, 32'h400);
        cyc(4 * TK);
        bus(1'b0, 2'h2, 32'h400, 32'h400);
        bus(1'b0, 2'h0, 32'h6, 32'h6);
        $display("test usb attach done");
        rst();
        load_ma <= 8'h40 + 8'($urandom_range(0, 100));
        setm(3'h1, 1'b0);
        chk(32'(status_n), 32'h1, "no load wake");
        setm(3'h1, 1'b1);
        chk({status_n, hi_lim}, 32'h1, "charging");
        load_ma <= 8'h14;
        cyc((LT - 2) * TK);
        load_ma <= 8'h40;
        cyc(TK);
        load_ma <= 8'h14;
        cyc((LT - 2) * TK);
        chk(32'(status_n), 32'h0, "timer restart");
        cyc(5 * TK);
        chk({status_n, lp_lim}, 32'h3, "low power");
        load_ma <= 8'h50;
        cyc(6);
        chk({status_n, disch, sw_on}, 32'h2, "discharge");
        cyc((DT - 1) * TK);
        chk(32'(disch), 32'h1, "discharge held");
        cyc(4 * TK);
        chk({status_n, disch, sw_on, hi_lim}, 32'h3, "recharge");
        bus(1'b0, 2'h2, 32'h10, 32'h70);
        bus(1'b0, 2'h0, 32'h18, 32'h18);
        $display("test load wake done");
        cyc(4);
        finish_test();
    end
endmodule
